// [include/lpc_pkg.sv]
// constants for the link control packet codec
package lpc_pkg;
  localparam logic [5:0] CMD_IDLE = 6'h00;
  localparam logic [5:0] CMD_FLUSH = 6'h02;
  localparam logic [5:0] CMD_READ_REPLY = 6'h30;
  localparam logic [5:0] CMD_TARGET_DONE = 6'h33;
  localparam logic [5:0] CMD_EXT_FLOW = 6'h37;
  localparam logic [5:0] CMD_BROADCAST = 6'h3a;
  localparam logic [5:0] CMD_FENCE = 6'h3c;
  localparam logic [5:0] CMD_ATOMIC = 6'h3d;
  localparam logic [5:0] CMD_EXT_DWORD = 6'h3e;
  localparam logic [1:0] SEL_ADDR_EXT = 2'h0;
  localparam logic [1:0] SEL_SRC_EXT = 2'h2;
  localparam logic [1:0] KIND_UNTRANSLATED = 2'h0;
  localparam logic [1:0] KIND_XLATE_REQ = 2'h1;
  localparam logic [1:0] KIND_TRANSLATED = 2'h2;
  localparam int CMD_LSB = 0;
  localparam int SEL_LSB = 6;
  localparam int FUNC_LSB = 8;
  localparam int DEV_LSB = 11;
  localparam int BUS_LSB = 16;
  localparam int KIND_LSB = 24;
  localparam int RSP_UNIT_LSB = 8;
  localparam int RSP_BRIDGE_BIT = 14;
  localparam int RSP_OVERTAKE_BIT = 15;
  localparam int RSP_ERR_LOW_BIT = 21;
  localparam int RSP_ERR_HIGH_BIT = 29;
  localparam int RSP_CHSET_LSB = 26;
  localparam logic [1:0] VC_NONE = 2'h0;
  localparam logic [1:0] VC_POSTED = 2'h1;
  localparam logic [1:0] VC_NONPOSTED = 2'h2;
  localparam logic [1:0] VC_RESPONSE = 2'h3;
  localparam logic [2:0] PT_INFO = 3'h0;
  localparam logic [2:0] PT_REQUEST = 3'h1;
  localparam logic [2:0] PT_REQ_ADDR = 3'h2;
  localparam logic [2:0] PT_REQ_ADDR_DATA = 3'h3;
  localparam logic [2:0] PT_RESPONSE = 3'h4;
  localparam logic [2:0] PT_RESP_DATA = 3'h5;
  localparam logic [2:0] PT_EXTENSION = 3'h6;
  localparam logic [2:0] PT_RESERVED = 3'h7;
endpackage : lpc_pkg

// [design/lpc_codec.sv]
// link control packet codec: extension insertion, decode and response build
//
// Summary of operation
// - source extension: selector 10b, code 111110b, ids, kind
// - never emit selector 01b or 11b
// - kind 00b untranslated, 10b translated
// - kind 01b reads only; 11b never generated
// - request without source extension means untranslated
// - forwarded source identity kept unchanged
// - crc recompute flagged for forwarded packets when generation disabled
// - unambiguous bridged source: secondary bus, its ids
// - ambiguous bridged source: own bus, device, function
// - originated packets use own bus register ids
// - response is four bytes with fixed fields
// - six-bit code gives type, channel, options
// - 000000 idle info, no channel
// - sized write: bit5 posted, address and data
// - sized read: nonposted, bit3 may overtake posted
// - bit2 dword length, bit1 isochronous
// - bit0 coherent; forced 1 off host memory
// - 110000 read reply, 110011 target done
// - 110111 extended flow credit info packet
// - 000010 flush nonposted, 111100 fence posted
// - 111110 extension dword, no channel
// - extension kind from first bit-time bits 7:6
// - source extension sent before address extension
// - reserved code flags protocol error
// - 111010 broadcast posted, 111101 atomic nonposted
`timescale 1ns/1ps
module lpc_codec
  import lpc_pkg::*;
(
  input wire logic sys_clk_in, // 50 MHz clock
  input wire logic rst_b_in, // async reset, active low
  // transmit request side
  input wire logic tx_valid_in, // request dword offered
  input wire logic [31:0] tx_req_in, // request first dword
  input wire logic tx_has_addr_ext_in, // address extension wanted
  input wire logic [31:0] tx_addr_ext_in, // address extension dword
  input wire logic [1:0] tx_src_mode_in, // 0 originate 1 forward 2 bridge
  input wire logic tx_src_known_in, // bridged source unambiguous
  input wire logic [7:0] tx_fwd_bus_in, // forwarded or secondary bus
  input wire logic [4:0] tx_fwd_dev_in, // forwarded or bridged device
  input wire logic [2:0] tx_fwd_func_in, // forwarded or bridged function
  input wire logic [1:0] tx_addr_kind_in, // wanted address kind
  input wire logic tx_non_host_in, // target not host memory
  input wire logic source_ident_generate_enable_in, // generate source ext
  input wire logic [7:0] own_bus_in, // bus number register
  input wire logic [4:0] own_dev_in, // own device number
  input wire logic [2:0] own_func_in, // own function number
  output logic tx_ready_out, // request accepted
  output logic tx_dw_valid_out, // dword on link
  output logic [31:0] tx_dw_out, // outgoing dword
  output logic tx_crc_regen_out, // forwarded packet needs new crc
  // response build
  input wire logic rsp_build_in, // build a response
  input wire logic rsp_with_data_in, // read reply instead of done
  input wire logic rsp_overtake_in, // may overtake posted
  input wire logic rsp_bridge_in, // bridge bit
  input wire logic [4:0] rsp_unit_in, // originator unit number
  input wire logic rsp_err_low_in, // low error flag
  input wire logic rsp_err_high_in, // high error flag
  input wire logic [2:0] rsp_chset_in, // response channel set
  output logic rsp_valid_out, // response ready
  output logic [31:0] rsp_dw_out, // four byte response
  // receive side
  input wire logic rx_valid_in, // incoming control dword
  input wire logic [31:0] rx_dw_in, // incoming dword
  output logic rx_req_valid_out, // merged entry ready
  output logic [31:0] rx_req_out, // request first dword
  output logic [31:0] rx_addr_ext_out, // address extension or zero
  output logic rx_has_src_out, // source extension present
  output logic [15:0] rx_src_id_out, // bus, device, function
  output logic [1:0] rx_addr_kind_out, // effective address kind
  output logic [2:0] rx_pkt_type_out, // packet type
  output logic [1:0] rx_vchan_out, // virtual channel
  output logic [3:0] rx_opts_out, // option bits of sized cmds
  output logic rx_proto_err_out // protocol error pulse
);
  typedef enum logic [1:0] {TX_IDLE, TX_SRC, TX_ADDR, TX_REQ} lpc_tx_t;
  lpc_tx_t tx_state_q;
  logic [31:0] tx_req_q, tx_addr_q, tx_src_q;
  logic tx_addr_ext_q;
  logic [7:0] sel_bus;
  logic [4:0] sel_dev;
  logic [2:0] sel_func;
  logic [1:0] sel_kind;
  logic [31:0] req_fixed;

  // source identity selection
  always_comb
  begin
    sel_bus = own_bus_in;
    sel_dev = own_dev_in;
    sel_func = own_func_in;
    if (tx_src_mode_in == 2'h1 || (tx_src_mode_in == 2'h2 && tx_src_known_in))
    begin
      sel_bus = tx_fwd_bus_in;
      sel_dev = tx_fwd_dev_in;
      sel_func = tx_fwd_func_in;
    end
    // ambiguous bridged source falls back to own ids
    sel_kind = tx_addr_kind_in;
    if (tx_addr_kind_in == 2'h3 ||
        (tx_addr_kind_in == KIND_XLATE_REQ && tx_req_in[5:4] != 2'h1))
      sel_kind = KIND_UNTRANSLATED;
    req_fixed = tx_req_in;
    // sized reads and writes must mark non-host access coherent
    if ((tx_req_in[5:4] == 2'h1 || tx_req_in[5:3] == 3'h1 || tx_req_in[5:3] == 3'h5) &&
        tx_non_host_in)
      req_fixed[0] = 1'b1;
  end

  assign tx_ready_out = (tx_state_q == TX_IDLE);

  logic tx_take;
  assign tx_take = tx_valid_in && tx_ready_out;

  // sequencer: the dwords of one request leave on back-to-back cycles
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tx_state_q <= TX_IDLE;
    else
    begin
      case (tx_state_q)
        TX_IDLE:
        begin
          if (tx_valid_in)
          begin
            if (source_ident_generate_enable_in)
              tx_state_q <= TX_SRC;
            else if (tx_has_addr_ext_in)
              tx_state_q <= TX_ADDR;
            else
              tx_state_q <= TX_REQ;
          end
        end
        TX_SRC: tx_state_q <= tx_addr_ext_q ? TX_ADDR : TX_REQ;
        TX_ADDR: tx_state_q <= TX_REQ;
        TX_REQ: tx_state_q <= TX_IDLE;
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end

  // captured on acceptance so the requester may change its inputs while we send
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_req_q <= 32'h0;
      tx_addr_q <= 32'h0;
      tx_src_q <= 32'h0;
      tx_addr_ext_q <= 1'b0;
    end
    else if (tx_take)
    begin
      tx_req_q <= req_fixed;
      tx_addr_q <= {tx_addr_ext_in[31:8], SEL_ADDR_EXT, CMD_EXT_DWORD};
      tx_addr_ext_q <= tx_has_addr_ext_in;
      tx_src_q <= {6'h0, sel_kind, sel_bus, sel_dev, sel_func,
                   SEL_SRC_EXT, CMD_EXT_DWORD};
    end
  end

  // one dword per cycle while sending; the last dword stays on the bus after
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      tx_dw_valid_out <= 1'b0;
      tx_dw_out <= 32'h0;
    end
    else
    begin
      tx_dw_valid_out <= (tx_state_q != TX_IDLE);
      case (tx_state_q)
        TX_SRC: tx_dw_out <= tx_src_q;
        TX_ADDR: tx_dw_out <= tx_addr_q;
        TX_REQ: tx_dw_out <= tx_req_q;
        default: tx_dw_out <= tx_dw_out;
      endcase
    end
  end

  // level flag, held until the next accepted request
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      tx_crc_regen_out <= 1'b0;
    else if (tx_take)
      tx_crc_regen_out <= (tx_src_mode_in == 2'h1) &&
                          !source_ident_generate_enable_in;
  end

  // response packet
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rsp_valid_out <= 1'b0;
      rsp_dw_out <= 32'h0;
    end
    else
    begin
      rsp_valid_out <= rsp_build_in;
      if (rsp_build_in)
      begin
        rsp_dw_out <= 32'h0;
        rsp_dw_out[5:0] <= rsp_with_data_in ? CMD_READ_REPLY : CMD_TARGET_DONE;
        rsp_dw_out[RSP_OVERTAKE_BIT] <= rsp_overtake_in;
        rsp_dw_out[RSP_BRIDGE_BIT] <= rsp_bridge_in;
        rsp_dw_out[RSP_UNIT_LSB +: 5] <= rsp_unit_in;
        rsp_dw_out[RSP_ERR_LOW_BIT] <= rsp_err_low_in;
        rsp_dw_out[RSP_ERR_HIGH_BIT] <= rsp_err_high_in;
        rsp_dw_out[RSP_CHSET_LSB +: 3] <= rsp_chset_in;
      end
    end
  end

  // command decode of incoming dword
  logic [5:0] rc;
  logic [2:0] d_type;
  logic [1:0] d_vc;
  logic [3:0] d_opt;
  always_comb
  begin
    rc = rx_dw_in[5:0];
    d_type = PT_RESERVED;
    d_vc = VC_NONE;
    d_opt = 4'h0;
    if (rc == CMD_IDLE || rc == CMD_EXT_FLOW)
    begin
      // info packets still make an entry so flow credits reach the consumer
      d_type = PT_INFO;
      d_vc = VC_NONE;
    end
    else if (rc == CMD_FLUSH)
    begin
      d_type = PT_REQUEST;
      d_vc = VC_NONPOSTED;
    end
    else if (rc == CMD_FENCE)
    begin
      d_type = PT_REQUEST;
      d_vc = VC_POSTED;
    end
    else if (rc[5:3] == 3'h1 || rc[5:3] == 3'h5)
    begin
      d_type = PT_REQ_ADDR_DATA;
      d_vc = rc[5] ? VC_POSTED : VC_NONPOSTED;
      d_opt = {1'b0, rc[2:0]};
    end
    else if (rc[5:4] == 2'h1)
    begin
      d_type = PT_REQ_ADDR;
      d_vc = VC_NONPOSTED;
      d_opt = rc[3:0];
    end
    else if (rc == CMD_READ_REPLY)
    begin
      d_type = PT_RESP_DATA;
      d_vc = VC_RESPONSE;
    end
    else if (rc == CMD_TARGET_DONE)
    begin
      d_type = PT_RESPONSE;
      d_vc = VC_RESPONSE;
    end
    else if (rc == CMD_BROADCAST)
    begin
      d_type = PT_REQ_ADDR;
      d_vc = VC_POSTED;
    end
    else if (rc == CMD_ATOMIC)
    begin
      d_type = PT_REQ_ADDR_DATA;
      d_vc = VC_NONPOSTED;
    end
    else if (rc == CMD_EXT_DWORD)
    begin
      d_type = PT_EXTENSION;
      d_vc = VC_NONE;
    end
  end

  // extension holding and merge
  logic rx_src_held_q, rx_addr_held_q;
  logic [31:0] rx_src_q, rx_addr_q;
  logic ext_bad;
  logic rx_take_ext;
  logic rx_take_err;
  logic rx_take_req;
  assign ext_bad = (d_type == PT_EXTENSION) &&
                   (rx_dw_in[7:6] == 2'h1 || rx_dw_in[7:6] == 2'h3 ||
                    (rx_dw_in[7:6] == SEL_SRC_EXT && rx_addr_held_q));
  assign rx_take_ext = rx_valid_in && (d_type == PT_EXTENSION) && !ext_bad;
  assign rx_take_err = rx_valid_in && (d_type == PT_RESERVED || ext_bad);
  assign rx_take_req = rx_valid_in && (d_type != PT_EXTENSION) && (d_type != PT_RESERVED);

  // held extensions live only until the next request or error; an error drops
  // them so a stray extension cannot attach itself to a later request
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_src_held_q <= 1'b0;
      rx_addr_held_q <= 1'b0;
      rx_src_q <= 32'h0;
      rx_addr_q <= 32'h0;
    end
    else if (rx_take_ext)
    begin
      if (rx_dw_in[7:6] == SEL_SRC_EXT)
      begin
        rx_src_held_q <= 1'b1;
        rx_src_q <= rx_dw_in;
      end
      else
      begin
        rx_addr_held_q <= 1'b1;
        rx_addr_q <= rx_dw_in;
      end
    end
    else if (rx_take_err || rx_take_req)
    begin
      rx_src_held_q <= 1'b0;
      rx_addr_held_q <= 1'b0;
    end
  end

  // one merged entry; its fields hold until the next entry
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_req_out <= 32'h0;
      rx_addr_ext_out <= 32'h0;
      rx_has_src_out <= 1'b0;
      rx_src_id_out <= 16'h0;
      rx_addr_kind_out <= 2'h0;
      rx_pkt_type_out <= 3'h0;
      rx_vchan_out <= 2'h0;
      rx_opts_out <= 4'h0;
    end
    else if (rx_take_req)
    begin
      rx_req_out <= rx_dw_in;
      rx_pkt_type_out <= d_type;
      rx_vchan_out <= d_vc;
      rx_opts_out <= d_opt;
      rx_addr_ext_out <= rx_addr_held_q ? {rx_addr_q[31:8], 8'h0} : 32'h0;
      rx_has_src_out <= rx_src_held_q;
      rx_src_id_out <= rx_src_held_q ? rx_src_q[BUS_LSB-8 +: 16] : 16'h0;
      rx_addr_kind_out <= rx_src_held_q ? rx_src_q[KIND_LSB +: 2]
                                        : KIND_UNTRANSLATED;
    end
  end

  // entry valid and protocol error are single-cycle pulses
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_req_valid_out <= 1'b0;
      rx_proto_err_out <= 1'b0;
    end
    else
    begin
      rx_req_valid_out <= rx_take_req;
      rx_proto_err_out <= rx_take_err;
    end
  end
endmodule : lpc_codec

// [bench/lpc_codec_monitor.sv]
// port assertions for the link control packet codec
`timescale 1ns/1ps
module lpc_codec_monitor
  import lpc_pkg::*;
(
  input wire logic sys_clk_in, // clock
  input wire logic rst_b_in, // reset
  input wire logic tx_valid_in, // offer
  input wire logic tx_ready_out, // accept
  input wire logic source_ident_generate_enable_in, // src ext on
  input wire logic [1:0] tx_src_mode_in, // id mode
  input wire logic tx_dw_valid_out, // dword valid
  input wire logic [31:0] tx_dw_out, // dword
  input wire logic tx_crc_regen_out, // crc flag
  input wire logic rsp_build_in, // build
  input wire logic rsp_with_data_in, // reply kind
  input wire logic [4:0] rsp_unit_in, // unit
  input wire logic rsp_valid_out, // built
  input wire logic [31:0] rsp_dw_out, // response
  input wire logic rx_valid_in, // rx valid
  input wire logic [31:0] rx_dw_in, // rx dword
  input wire logic rx_req_valid_out, // entry
  input wire logic [1:0] rx_vchan_out, // channel
  input wire logic rx_proto_err_out // error
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  logic tk;
  logic en;
  assign tk = tx_valid_in && tx_ready_out;
  assign en = source_ident_generate_enable_in;
  a_src_head_ok:
    assert property (tk && en |-> ##2 tx_dw_valid_out && tx_dw_out[7:0] == 8'hbe)
    else $error("bad source extension head");
  a_sel_not_rsvd:
    assert property (tx_dw_valid_out && tx_dw_out[5:0] == CMD_EXT_DWORD |-> !tx_dw_out[6])
    else $error("reserved selector sent");
  a_kind_not_rsvd:
    assert property (tk && en |-> ##2 tx_dw_out[25:24] != 2'h3)
    else $error("reserved address kind sent");
  a_tx_first_dword:
    assert property (tk |-> ##2 tx_dw_valid_out)
    else $error("no dword after accept");
  a_crc_regen_set:
    assert property (tk && tx_src_mode_in == 2'h1 && !en |=> tx_crc_regen_out)
    else $error("crc regeneration not flagged");
  a_rsp_code_ok:
    assert property (rsp_build_in |=> rsp_valid_out &&
      rsp_dw_out[5:0] == ($past(rsp_with_data_in) ? CMD_READ_REPLY : CMD_TARGET_DONE))
    else $error("wrong response code");
  a_rsp_unit_ok:
    assert property (rsp_build_in |=> rsp_dw_out[12:8] == $past(rsp_unit_in) && !rsp_dw_out[13])
    else $error("wrong response unit field");
  a_rx_fence_posted:
    assert property (rx_valid_in && rx_dw_in[5:0] == CMD_FENCE |=>
      rx_req_valid_out && rx_vchan_out == VC_POSTED)
    else $error("fence not posted entry");
  a_rx_rsvd_err:
    assert property (rx_valid_in && rx_dw_in[5:3] == 3'b100 |=> rx_proto_err_out && !rx_req_valid_out)
    else $error("reserved code not flagged");
  c_ext_sent: cover property (tk && en);
  c_rsp_built: cover property (rsp_build_in);
  c_rx_error: cover property (rx_proto_err_out);
endmodule : lpc_codec_monitor

bind lpc_codec lpc_codec_monitor mon (.*);

// [bench/lpc_link_peer.sv]
// neighbouring link node: sends control dwords, collects received ones
`timescale 1ns/1ps
module lpc_link_peer (
  input wire logic clk_in, // clock
  input wire logic dw_valid_in, // dword from codec
  input wire logic [31:0] dw_in, // dword from codec
  output logic vld_out, // dword to codec
  output logic [31:0] dw_out // dword to codec
);
  logic [31:0] got[$];
  initial
  begin
    vld_out = 1'b0;
    dw_out = 32'h0;
  end
  always @(posedge clk_in)
    if (dw_valid_in)
      got.push_back(dw_in);
  // dwords go back to back, in the order the caller lists them
  task automatic put(input logic [31:0] q[$]);
    foreach (q[i])
    begin
      @(posedge clk_in);
      vld_out <= 1'b1;
      dw_out <= q[i];
    end
    @(posedge clk_in);
    vld_out <= 1'b0;
    // released line shows the inverse so a stale copy cannot pass
    dw_out <= ~q[q.size()-1];
  endtask : put
endmodule : lpc_link_peer

// [bench/lpc_codec_tb.sv]
// self-checking bench for the link control packet codec
`timescale 1ns/1ps
module lpc_codec_tb;
  import lpc_pkg::*;
  `define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin err_count++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
  logic sys_clk_in, rst_b_in, tx_valid_in, tx_has_addr_ext_in, tx_src_known_in, tx_non_host_in;
  logic source_ident_generate_enable_in, tx_ready_out, tx_dw_valid_out, tx_crc_regen_out;
  logic rsp_build_in, rsp_with_data_in, rsp_overtake_in, rsp_bridge_in, rsp_err_low_in;
  logic rsp_err_high_in, rsp_valid_out, rx_valid_in, rx_req_valid_out, rx_has_src_out;
  logic rx_proto_err_out;
  logic [31:0] tx_req_in, tx_addr_ext_in, tx_dw_out, rsp_dw_out, rx_dw_in, rx_req_out;
  logic [31:0] rx_addr_ext_out, w, a, d, e;
  logic [1:0] tx_src_mode_in, tx_addr_kind_in, rx_addr_kind_out, rx_vchan_out;
  logic [7:0] tx_fwd_bus_in, own_bus_in;
  logic [4:0] tx_fwd_dev_in, own_dev_in, rsp_unit_in;
  logic [2:0] tx_fwd_func_in, own_func_in, rsp_chset_in, rx_pkt_type_out;
  logic [15:0] rx_src_id_out, s;
  logic [3:0] rx_opts_out;
  int err_count, cmp_count;
  lpc_codec uut (.*);
  lpc_link_peer peer (.clk_in(sys_clk_in), .dw_valid_in(tx_dw_valid_out), .dw_in(tx_dw_out),
    .vld_out(rx_valid_in), .dw_out(rx_dw_in));
  initial
  begin
    sys_clk_in = 1'b0;
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  function automatic logic [4:0] dec(input logic [5:0] c);
    casez (c)
      6'h00, 6'h37: return {PT_INFO, VC_NONE};
      6'h02: return {PT_REQUEST, VC_NONPOSTED};
      6'b?01???: return {PT_REQ_ADDR_DATA, c[5] ? VC_POSTED : VC_NONPOSTED};
      6'b01????: return {PT_REQ_ADDR, VC_NONPOSTED};
      6'h30: return {PT_RESP_DATA, VC_RESPONSE};
      6'h33: return {PT_RESPONSE, VC_RESPONSE};
      6'h3a: return {PT_REQ_ADDR, VC_POSTED};
      6'h3c: return {PT_REQUEST, VC_POSTED};
      6'h3d: return {PT_REQ_ADDR_DATA, VC_NONPOSTED};
      default: return {PT_RESERVED, VC_NONE};
    endcase
  endfunction : dec
  task automatic rx_chk(input logic [31:0] q[$], input logic er, hs, input logic [4:0] x);
    peer.put(q);
    #1;
    `CHK("rx error", er, rx_proto_err_out)
    `CHK("rx entry", !er, rx_req_valid_out)
    if (!er)
    begin
      `CHK("rx class", x, {rx_pkt_type_out, rx_vchan_out})
      `CHK("rx has src", hs, rx_has_src_out)
    end
  endtask : rx_chk
  task automatic tx_op(input logic [5:0] c, input logic ae, en, nh, kn, input logic [1:0] md, kd);
    logic [31:0] q[$];
    logic [31:0] r;
    logic [15:0] f, id;
    logic [1:0] k;
    int n;
    f = $urandom;
    r = $urandom;
    r[5:0] = c;
    k = (kd == 2'h3 || (kd == 2'h1 && c[5:4] != 2'b01)) ? 2'h0 : kd;
    id = (md == 2'h1 || (md == 2'h2 && kn)) ? f : {own_bus_in, own_dev_in, own_func_in};
    if (en)
      q.push_back({6'h0, k, id, 8'hbe});
    if (ae)
      q.push_back({a[31:8], 8'h3e});
    q.push_back(r | 32'(nh && (c[5:4] == 2'b01 || c[4:3] == 2'b01)));
    peer.got.delete();
    `CHK("tx ready", 1'b1, tx_ready_out)
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b1;
    {tx_req_in, tx_has_addr_ext_in, tx_addr_ext_in, tx_src_mode_in} <= {r, ae, a, md};
    {tx_src_known_in, tx_addr_kind_in, tx_non_host_in} <= {kn, kd, nh};
    {tx_fwd_bus_in, tx_fwd_dev_in, tx_fwd_func_in, source_ident_generate_enable_in} <= {f, en};
    @(posedge sys_clk_in);
    tx_valid_in <= 1'b0;
    for (n = 0; n < 9 && peer.got.size() < q.size(); n++)
      @(posedge sys_clk_in);
    #1;
    if (n == 9)
    begin
      err_count++;
      end_of_test();
    end
    foreach (q[i])
      `CHK("tx dword", q[i], peer.got[i])
    `CHK("tx crc", md == 2'h1 && !en, tx_crc_regen_out)
  endtask : tx_op
  initial
  begin
    {tx_valid_in, tx_req_in, tx_has_addr_ext_in, tx_addr_ext_in, tx_src_mode_in} = '0;
    {tx_src_known_in, tx_addr_kind_in, tx_non_host_in, source_ident_generate_enable_in} = '0;
    {tx_fwd_bus_in, tx_fwd_dev_in, tx_fwd_func_in, rsp_build_in, rsp_with_data_in} = '0;
    {rsp_overtake_in, rsp_bridge_in, rsp_unit_in, rsp_err_low_in, rsp_err_high_in} = '0;
    rsp_chset_in = 3'h0;
    err_count = 0;
    cmp_count = 0;
    rst_b_in = 1'b0;
    w = $urandom(32'hbce2);
    {own_bus_in, own_dev_in, own_func_in} = 16'($urandom);
    a = $urandom;
    a[31] = 1'b1;
    s = $urandom;
    repeat (6) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    for (int c = 0; c < 64; c++)
      if (c != 62)
      begin
        d = $urandom;
        d[5:0] = 6'(c);
        rx_chk('{d}, dec(d[5:0]) == {PT_RESERVED, VC_NONE}, 1'b0, dec(d[5:0]));
        if (d[5:4] == 2'b01 || d[4:3] == 2'b01)
          `CHK("opts", {d[3] && d[5:4] == 2'b01, d[2:0]}, rx_opts_out)
      end
    $display("test rx command map done");
    d[5:0] = 6'h1d;
    for (int k = 0; k < 3; k++)
    begin
      rx_chk('{{6'h0, 2'(k), s, 8'hbe}, {a[31:8], 8'h3e}, d}, 1'b0, 1'b1, dec(6'h1d));
      `CHK("src id", s, rx_src_id_out)
      `CHK("kind", 2'(k), rx_addr_kind_out)
      `CHK("addr ext", {a[31:8], 8'h0}, rx_addr_ext_out)
      `CHK("req", d, rx_req_out)
    end
    rx_chk('{{a[31:8], 8'h7e}}, 1'b1, 1'b0, 5'h0);
    rx_chk('{{a[31:8], 8'hfe}}, 1'b1, 1'b0, 5'h0);
    rx_chk('{{a[31:8], 8'h3e}, {8'h02, s, 8'hbe}}, 1'b1, 1'b0, 5'h0);
    rx_chk('{d}, 1'b0, 1'b0, dec(6'h1d));
    `CHK("kind", 2'h0, rx_addr_kind_out)
    $display("test rx extensions done");
    for (int i = 0; i < 24; i++)
    begin
      w = $urandom;
      tx_op(w[6] ? {2'b01, w[3:0]} : {w[5], 2'b01, w[2:0]}, w[7], w[8], w[9], w[10],
        2'(w[12:11] % 3), w[14:13]);
    end
    tx_op(CMD_FLUSH, 1'b1, 1'b1, 1'b1, 1'b0, 2'h2, 2'h1);
    tx_op(6'h14, 1'b0, 1'b0, 1'b0, 1'b1, 2'h1, 2'h1);
    $display("test tx extensions done");
    for (int i = 0; i < 8; i++)
    begin
      w = $urandom;
      @(posedge sys_clk_in);
      rsp_build_in <= 1'b1;
      {rsp_with_data_in, rsp_overtake_in, rsp_bridge_in, rsp_unit_in} <= w[12:5];
      {rsp_err_low_in, rsp_err_high_in, rsp_chset_in} <= w[4:0];
      e = 32'h0;
      e[5:0] = w[12] ? CMD_READ_REPLY : CMD_TARGET_DONE;
      {e[15:14], e[12:8], e[21], e[29], e[28:26]} = w[11:0];
      @(posedge sys_clk_in);
      rsp_build_in <= 1'b0;
      #1;
      `CHK("rsp valid", 1'b1, rsp_valid_out)
      `CHK("rsp dword", e, rsp_dw_out)
    end
    $display("test responses done");
    end_of_test();
  end
endmodule : lpc_codec_tb
